// ===== rtl/acs_defines.vh
// Register addresses, field positions, reset values and codes for the converter control block
`ifndef ACS_DEFINES_VH
`define ACS_DEFINES_VH
`define ACS_ADDR_CTRL0 8'hDC
`define ACS_ADDR_CTRL1 8'hDD
`define ACS_ADDR_DRLO 8'hDE
`define ACS_ADDR_DRHI 8'hDF
`define ACS_ADDR_ACCCTL 8'hE1
`define ACS_ADDR_SUM0 8'hE2
`define ACS_ADDR_SUM1 8'hE3
`define ACS_ADDR_SUM2 8'hE4
`define ACS_ADDR_SUM3 8'hE5
`define ACS_ADDR_TRIM 8'hE6
`define ACS_RST_CTRL0 8'h30
`define ACS_RST_CTRL1 8'h00
`define ACS_RST_DRLO 8'h1B
`define ACS_RST_DRHI 3'h6
`define ACS_RST_ACCCTL 8'h00
`define ACS_RST_TRIM 8'h00
`define ACS_TRIM_OFF_A 8'h00
`define ACS_TRIM_OFF_B 8'h80
`define ACS_CTRL0_MASK 8'h7F
`define ACS_CTRL1_MASK 8'h70
`define ACS_BIT_REFEN 5
`define ACS_BIT_REFHI 4
`define ACS_BIT_BUF 3
`define ACS_BIT_SIGN 6
`define ACS_BIT_TRIMSIGN 7
`define ACS_MODE_CPU 2'h0
`define ACS_MODE_ADC 2'h1
`define ACS_MODE_SHIFT 2'h2
`define ACS_MODE_ACCSH 2'h3
`define ACS_CAL_NONE 3'h0
`define ACS_CAL_LAST 3'h5
`define ACS_SHIFT_CLKS 3'h4
`define ACS_GAIN_HI 2
`define ACS_GAIN_LO 0
`define ACS_CAL_HI 2
`define ACS_CAL_LO 0
`define ACS_SM_HI 5
`define ACS_SM_LO 4
`define ACS_CNT_HI 5
`define ACS_CNT_LO 3
`define ACS_SHF_HI 2
`define ACS_SHF_LO 0
`define ACS_MODE_HI 7
`define ACS_MODE_LO 6
`define ACS_DRHI_HI 2
`define ACS_TRIM_MAG_HI 6
`define ACS_ACC_CLEAR 8'h00
`endif

// ===== rtl/acs_shifter.v
// Arithmetic right shifter that takes a fixed number of clocks per operation
`include "acs_defines.vh"
module acs_shifter #(
   parameter W = 32
) (
   // Clock and reset
   input wire core_clk,
   input wire rstn,
   // Request
   input wire start,
   input wire [W-1:0] din,
   input wire [2:0] amount,
   input wire arith,
   // Result
   output reg busy,
   output reg done,
   output reg [W-1:0] dout
);
   reg [2:0] cnt;
   wire [W-1:0] shifted;
   wire [W-1:0] fill;
   assign fill = (arith && din[W-1]) ? {W{1'b1}} : {W{1'b0}};
   // Shift by amount+1; sign fill keeps bipolar totals signed
   assign shifted = (din >> ({1'b0, amount} + 4'h1)) |
      ~({W{1'b1}} >> ({1'b0, amount} + 4'h1)) & fill;
   always @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         busy <= 1'b0;
         done <= 1'b0;
         cnt <= 3'h0;
         dout <= {W{1'b0}};
      end else begin
         done <= 1'b0;
         if (start && !busy) begin
            busy <= 1'b1;
            cnt <= 3'h1;
            dout <= shifted;
         end else if (busy) begin
            if (cnt == `ACS_SHIFT_CLKS - 3'h1) begin
               busy <= 1'b0;
               done <= 1'b1;
            end else begin
               cnt <= cnt + 3'h1;
            end
         end
      end
   end
endmodule // acs_shifter

// ===== rtl/acs_control.v
// Converter control registers and summation/shift accumulator
// What the document asks of this block and its software
// RULE1 - Gain select decodes to gain two-to-code
// RULE2 - Reference enable bit five, default on
// RULE3 - Reference level bit four, default high
// RULE4 - Input buffer enable bit three, default off
// RULE5 - Signedness bit six: bipolar or clamped unipolar
// RULE6 - Settling field picks auto, fast, sinc2, sinc3
// RULE7 - Calibration write starts calibration, reads zero
// RULE8 - Eleven-bit decimation ratio sets word rate
// RULE9 - Accumulator powered down with converter
// RULE10 - Writing zero control clears accumulator
// RULE11 - Bipolar samples sign-extended before accumulating
// RULE12 - Mode 00 adds CPU value on byte0 write
// RULE13 - Mode 01 accumulates converter results by count
// RULE14 - Mode 10 shifts amount plus one, four clocks
// RULE15 - Mode 11 accumulates then shifts
// RULE16 - Count selects two-to-(code+1); completion interrupts
// RULE17 - Reading byte0 clears summation interrupt
// RULE18 - Software also clears auxiliary interrupt flag
// RULE19 - Accumulator mapped over four consecutive bytes
// RULE20 - Trim disabled at 00h or 80h
// RULE21 - Trim sign bit seven, magnitude six-zero
// RULE22 - Software clears trim before offset calibration
// RULE23 - Converter powerdown stops converter, reference, summation
// RULE24 - Converter clock divides system clock by divider+1
// RULE25 - Reserved calibration codes mean no calibration
`include "acs_defines.vh"
module acs_control #(
   parameter AW = 8,
   parameter SW = 24
) (
   // Clock and reset
   input wire core_clk,
   input wire rstn,
   // Special function register port
   input wire [AW-1:0] sfr_addr,
   input wire sfr_wr,
   input wire sfr_rd,
   input wire [7:0] sfr_wdata,
   output reg [7:0] sfr_rdata,
   // Neighbouring controls
   input wire converter_powerdown,
   input wire [6:0] clock_divider,
   // Converter result stream
   input wire sample_valid,
   input wire [SW-1:0] sample_data,
   // Converter analog controls
   output wire reference_enable,
   output wire reference_level_select,
   output wire input_buffer_enable,
   output wire [7:0] gain_value,
   output wire signedness_select,
   output wire [1:0] filter_settling_select,
   output wire [10:0] decimation_ratio,
   output reg cal_start,
   output reg [2:0] trim_mode_select,
   output wire trim_active,
   output wire trim_negative,
   output wire [6:0] trim_magnitude,
   output reg converter_clk_en,
   output wire converter_power_on,
   // Summation interrupt
   output reg sum_irq
);
   reg [7:0] ctrl0;
   reg [7:0] ctrl1;
   reg [7:0] dr_lo;
   reg [2:0] dr_hi;
   reg [7:0] acc_ctl;
   reg [7:0] trim;
   reg [31:0] acc;
   reg [31:0] cpu_stage;
   reg [8:0] sum_cnt;
   reg [6:0] clk_div;
   reg shift_pend;
   wire [1:0] mode;
   wire [8:0] sum_target;
   wire [31:0] sample_ext;
   wire adc_mode;
   wire sh_busy;
   wire sh_done;
   wire [31:0] sh_out;
   wire sh_start;
   wire wr_ctl;
   wire wr_sum0;
   wire sum_last;
   wire wr_c0;
   wire wr_c1;
   wire wr_drlo;
   wire wr_drhi;
   wire wr_trim;
   wire wr_sum1;
   wire wr_sum2;
   wire wr_sum3;
   wire rd_sum0;
   wire acc_take;
   wire [2:0] gain_code;
   wire [2:0] cal_code;
   wire [2:0] count_code;
   wire [2:0] shift_code;
   wire [1:0] new_mode;
   reg [7:0] next_rdata;
   reg [6:0] next_clk_div;
   reg next_clk_en;

   // Field extraction
   assign mode = acc_ctl[`ACS_MODE_HI:`ACS_MODE_LO];
   assign gain_code = ctrl0[`ACS_GAIN_HI:`ACS_GAIN_LO];
   assign count_code = acc_ctl[`ACS_CNT_HI:`ACS_CNT_LO];
   assign shift_code = acc_ctl[`ACS_SHF_HI:`ACS_SHF_LO];
   assign cal_code = sfr_wdata[`ACS_CAL_HI:`ACS_CAL_LO];
   assign new_mode = sfr_wdata[`ACS_MODE_HI:`ACS_MODE_LO];

   // Analog controls decoded from the stored registers and converter_powerdown
   assign reference_enable = ctrl0[`ACS_BIT_REFEN] && !converter_powerdown; // RULE2 RULE23
   assign reference_level_select = ctrl0[`ACS_BIT_REFHI]; // RULE3
   assign input_buffer_enable = ctrl0[`ACS_BIT_BUF]; // RULE4
   assign gain_value = 8'h01 << gain_code; // RULE1
   assign signedness_select = ctrl1[`ACS_BIT_SIGN]; // RULE5
   assign filter_settling_select = ctrl1[`ACS_SM_HI:`ACS_SM_LO]; // RULE6
   assign decimation_ratio = {dr_hi, dr_lo}; // RULE8
   assign trim_active = (trim != `ACS_TRIM_OFF_A) && (trim != `ACS_TRIM_OFF_B); // RULE20
   assign trim_negative = trim[`ACS_BIT_TRIMSIGN]; // RULE21
   assign trim_magnitude = trim[`ACS_TRIM_MAG_HI:0]; // RULE21
   assign converter_power_on = !converter_powerdown; // RULE23

   // Bipolar samples are sign-extended, unipolar zero-extended
   assign sample_ext = signedness_select ? {{(32-SW){1'b0}}, sample_data} :
      {{(32-SW){sample_data[SW-1]}}, sample_data}; // RULE11
   assign adc_mode = (mode == `ACS_MODE_ADC) || (mode == `ACS_MODE_ACCSH); // RULE13 RULE15
   // A sample is refused while a shift waits or runs, so no total is lost
   assign acc_take = sample_valid && adc_mode && !sh_busy && !shift_pend; // RULE13
   assign sum_target = 9'h002 << count_code; // RULE16
   assign sum_last = (sum_cnt + 9'h001) >= sum_target;

   // Register strobes
   assign wr_ctl = sfr_wr && (sfr_addr == `ACS_ADDR_ACCCTL);
   assign wr_sum0 = sfr_wr && (sfr_addr == `ACS_ADDR_SUM0);
   assign wr_sum1 = sfr_wr && (sfr_addr == `ACS_ADDR_SUM1);
   assign wr_sum2 = sfr_wr && (sfr_addr == `ACS_ADDR_SUM2);
   assign wr_sum3 = sfr_wr && (sfr_addr == `ACS_ADDR_SUM3);
   assign wr_c0 = sfr_wr && (sfr_addr == `ACS_ADDR_CTRL0);
   assign wr_c1 = sfr_wr && (sfr_addr == `ACS_ADDR_CTRL1);
   assign wr_drlo = sfr_wr && (sfr_addr == `ACS_ADDR_DRLO);
   assign wr_drhi = sfr_wr && (sfr_addr == `ACS_ADDR_DRHI);
   assign wr_trim = sfr_wr && (sfr_addr == `ACS_ADDR_TRIM);
   assign rd_sum0 = sfr_rd && (sfr_addr == `ACS_ADDR_SUM0);
   assign sh_start = shift_pend && !sh_busy;

   acs_shifter #(.W(32)) u_shift (
      .core_clk(core_clk),
      .rstn(rstn),
      .start(sh_start),
      .din(acc),
      .amount(shift_code),
      .arith(!signedness_select),
      .busy(sh_busy),
      .done(sh_done),
      .dout(sh_out)
   );

   // Converter control 0; the unused top bit is masked and reads zero
   always @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         ctrl0 <= `ACS_RST_CTRL0;
      end else if (wr_c0) begin
         ctrl0 <= sfr_wdata & `ACS_CTRL0_MASK; // RULE1 RULE2 RULE3 RULE4
      end
   end

   // Converter control 1; the calibration field is not stored, so it reads zero
   always @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         ctrl1 <= `ACS_RST_CTRL1;
      end else if (wr_c1) begin
         ctrl1 <= sfr_wdata & `ACS_CTRL1_MASK; // RULE5 RULE6 RULE7
      end
   end

   // Any write starts a calibration; reserved codes run none
   always @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         cal_start <= 1'b0;
         trim_mode_select <= `ACS_CAL_NONE;
      end else begin
         cal_start <= wr_c1; // RULE7
         if (wr_c1) begin
            if (cal_code > `ACS_CAL_LAST) begin
               trim_mode_select <= `ACS_CAL_NONE; // RULE25
            end else begin
               trim_mode_select <= cal_code; // RULE7
            end
         end
      end
   end

   // Decimation ratio low byte
   always @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         dr_lo <= `ACS_RST_DRLO;
      end else if (wr_drlo) begin
         dr_lo <= sfr_wdata; // RULE8
      end
   end

   // Decimation ratio high bits; the rest of the byte is dropped
   always @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         dr_hi <= `ACS_RST_DRHI;
      end else if (wr_drhi) begin
         dr_hi <= sfr_wdata[`ACS_DRHI_HI:0]; // RULE8
      end
   end

   // Summation control; a write also restarts the count below
   always @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         acc_ctl <= `ACS_RST_ACCCTL;
      end else if (wr_ctl) begin
         acc_ctl <= sfr_wdata; // RULE13 RULE14 RULE15 RULE16
      end
   end

   // Input offset trim
   always @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         trim <= `ACS_RST_TRIM;
      end else if (wr_trim) begin
         trim <= sfr_wdata; // RULE20 RULE21
      end
   end

   // Converter clock enable, one pulse every divider+1 system clocks
   always @* begin
      next_clk_div = clk_div + 7'h01;
      next_clk_en = 1'b0;
      if (converter_powerdown) begin
         next_clk_div = 7'h00;
      end else if (clk_div >= clock_divider) begin
         // Greater-or-equal so a divider lowered mid-count cannot overrun
         next_clk_div = 7'h00;
         next_clk_en = 1'b1; // RULE24
      end
   end

   always @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         clk_div <= 7'h00;
         converter_clk_en <= 1'b0;
      end else begin
         clk_div <= next_clk_div;
         converter_clk_en <= next_clk_en; // RULE23
      end
   end

   // Staging word for processor byte writes; in mode 00 byte0 also goes straight into the sum
   always @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         cpu_stage <= 32'h0000_0000;
      end else if (!converter_powerdown) begin
         if (wr_sum0) begin
            cpu_stage[7:0] <= sfr_wdata; // RULE19
         end
         if (wr_sum1) begin
            cpu_stage[15:8] <= sfr_wdata; // RULE19
         end
         if (wr_sum2) begin
            cpu_stage[23:16] <= sfr_wdata; // RULE19
         end
         if (wr_sum3) begin
            cpu_stage[31:24] <= sfr_wdata; // RULE19
         end
      end
   end

   // Accumulator; the processor sum uses the staged upper bytes
   always @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         acc <= 32'h0000_0000;
         sum_cnt <= 9'h000;
         shift_pend <= 1'b0;
         sum_irq <= 1'b0;
      end else if (converter_powerdown) begin
         // Summation is held off while the converter sleeps
         sum_cnt <= 9'h000; // RULE9 RULE23
         shift_pend <= 1'b0;
      end else begin
         if (rd_sum0)
            sum_irq <= 1'b0; // RULE17
         if (wr_ctl) begin
            sum_cnt <= 9'h000;
            shift_pend <= (new_mode == `ACS_MODE_SHIFT); // RULE14
            if (sfr_wdata == `ACS_ACC_CLEAR)
               acc <= 32'h0000_0000; // RULE10
         end else if (sh_done) begin
            acc <= sh_out; // RULE14 RULE15
            if (mode == `ACS_MODE_ACCSH)
               sum_irq <= 1'b1; // RULE16
         end else if (sh_start) begin
            shift_pend <= 1'b0;
         end else if (wr_sum0 && mode == `ACS_MODE_CPU) begin
            acc <= acc + {cpu_stage[31:8], sfr_wdata}; // RULE12
         end else if (acc_take) begin
            acc <= acc + sample_ext; // RULE13
            if (sum_last) begin
               sum_cnt <= 9'h000;
               // Event set wins over a same-cycle read clear
               if (mode == `ACS_MODE_ACCSH)
                  shift_pend <= 1'b1; // RULE15
               else
                  sum_irq <= 1'b1; // RULE16
            end else begin
               sum_cnt <= sum_cnt + 9'h001;
            end
         end
      end
   end

   // Read data; the calibration field always reads zero since it is not stored
   always @* begin
      next_rdata = sfr_rdata;
      if (sfr_rd) begin
         case (sfr_addr)
            `ACS_ADDR_CTRL0: next_rdata = ctrl0;
            `ACS_ADDR_CTRL1: next_rdata = ctrl1; // RULE7
            `ACS_ADDR_DRLO: next_rdata = dr_lo;
            `ACS_ADDR_DRHI: next_rdata = {5'h00, dr_hi};
            `ACS_ADDR_ACCCTL: next_rdata = acc_ctl;
            `ACS_ADDR_SUM0: next_rdata = acc[7:0]; // RULE19
            `ACS_ADDR_SUM1: next_rdata = acc[15:8]; // RULE19
            `ACS_ADDR_SUM2: next_rdata = acc[23:16]; // RULE19
            `ACS_ADDR_SUM3: next_rdata = acc[31:24]; // RULE19
            `ACS_ADDR_TRIM: next_rdata = trim;
            default: next_rdata = 8'h00;
         endcase
      end
   end

   // Registered so the port holds its value until the next read
   always @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         sfr_rdata <= 8'h00;
      end else begin
         sfr_rdata <= next_rdata;
      end
   end
endmodule // acs_control

// ===== dv/acs_control_checker.sv
// Assertion checker for the converter control block
module acs_control_checker (
   // Clock and reset
   input wire core_clk,
   input wire rstn,
   // Register port and neighbouring controls
   input wire [7:0] sfr_addr,
   input wire sfr_wr,
   input wire sfr_rd,
   input wire [7:0] sfr_wdata,
   input wire converter_powerdown,
   input wire [6:0] clock_divider,
   // Watched outputs
   input wire reference_enable,
   input wire [7:0] gain_value,
   input wire cal_start,
   input wire [2:0] trim_mode_select,
   input wire trim_active,
   input wire trim_negative,
   input wire converter_clk_en,
   input wire converter_power_on,
   input wire sum_irq
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rstn);
   sequence wr_c0; sfr_wr && sfr_addr == 8'hDC; endsequence
   sequence wr_c1; sfr_wr && sfr_addr == 8'hDD; endsequence
   // Powerdown may hold off the pulse that ends a divider gap, so it also ends the wait
   sequence en_gap; (!converter_clk_en) [*3] ##1 (converter_clk_en || converter_powerdown);
   endsequence
   AST_GAIN: assert property (wr_c0 |=> gain_value == (8'h01 << $past(sfr_wdata[2:0])))
      else $error("gain decode");
   AST_REF: assert property (wr_c0 |=> reference_enable == $past(sfr_wdata[5]))
      else $error("reference enable");
   AST_CAL: assert property (wr_c1 |=> cal_start)
      else $error("calibration start");
   AST_RSV: assert property (wr_c1 ##0 sfr_wdata[2:1] == 2'h3 |=> trim_mode_select == 3'h0)
      else $error("reserved calibration");
   AST_TRIM: assert property (sfr_wr && sfr_addr == 8'hE6 |=>
      trim_active == ($past(sfr_wdata[6:0]) != 7'h00) && trim_negative == $past(sfr_wdata[7]))
      else $error("trim decode");
   AST_PWR: assert property (converter_powerdown |-> !reference_enable &&
      !converter_power_on && !(converter_clk_en && $past(converter_powerdown)))
      else $error("powerdown");
   AST_DIV: assert property (converter_clk_en && clock_divider == 7'h03 |=> en_gap)
      else $error("clock divider");
   AST_IRQ: assert property ($fell(sum_irq) |->
      $past(sfr_rd && sfr_addr == 8'hE2) || $past(sfr_rd && sfr_addr == 8'hE2, 2))
      else $error("irq clear");
endmodule // acs_control_checker
bind acs_control acs_control_checker acs_control_checker_i (.*);

// ===== dv/acs_cpu_model.sv
// Processor-side model that reaches the block through its register port
module acs_cpu_model (
   // Clock
   input wire core_clk,
   // Register port
   output logic [7:0] sfr_addr = 8'h00,
   output logic sfr_wr = 1'b0,
   output logic sfr_rd = 1'b0,
   output logic [7:0] sfr_wdata = 8'h00,
   input wire [7:0] sfr_rdata
);
   timeunit 1ns;
   timeprecision 1ns;
   // Idle bus shows inverted values so a stale address or datum cannot pass
   task automatic wr(input logic [7:0] a, d);
      @(negedge core_clk);
      sfr_addr = a;
      sfr_wdata = d;
      sfr_wr = 1'b1;
      @(negedge core_clk);
      sfr_wr = 1'b0;
      sfr_addr = ~a;
      sfr_wdata = ~d;
      @(negedge core_clk);
   endtask
   // Auxiliary flag clearing after a byte0 read lives outside this block
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(negedge core_clk);
      sfr_addr = a;
      sfr_rd = 1'b1;
      @(negedge core_clk);
      sfr_rd = 1'b0;
      sfr_addr = ~a;
      @(negedge core_clk);
      d = sfr_rdata;
   endtask
endmodule // acs_cpu_model

// ===== dv/testbench.sv
// Self-checking bench for the converter control block
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   logic core_clk = 1'b0;
   logic rstn = 1'b0;
   logic converter_powerdown = 1'b0;
   logic [6:0] clock_divider = 7'h03;
   logic sample_valid = 1'b0;
   logic [23:0] sample_data = 24'h000000;
   logic [7:0] rv;
   logic [31:0] acc;
   int n_errors = 0;
   int comparisons = 0;
   int cycles = 0;
   wire [7:0] sfr_addr, sfr_wdata, sfr_rdata, gain_value;
   wire [6:0] trim_magnitude;
   wire [10:0] decimation_ratio;
   wire [2:0] trim_mode_select;
   wire [1:0] filter_settling_select;
   wire sfr_wr, sfr_rd, reference_enable, reference_level_select, input_buffer_enable;
   wire signedness_select, cal_start, trim_active, trim_negative, converter_clk_en;
   wire converter_power_on, sum_irq;
   acs_control acs_control_i (.*);
   acs_cpu_model acs_cpu_model_i (.*);
   always #50 core_clk = ~core_clk;
   // A hang costs one mismatch and ends the run
   always @(posedge core_clk) begin
      cycles++;
      if (cycles == 5000) begin
         n_errors++;
         final_report();
      end
   end
   task final_report;
      if (n_errors == 0 && comparisons > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   task chk(input string n, input logic [31:0] e, s);
      comparisons++;
      if (s !== e) begin
         n_errors++;
         $display("BAD %s exp %h got %h", n, e, s);
      end
   endtask
   task smp(input logic [23:0] d);
      @(negedge core_clk);
      sample_data = d;
      sample_valid = 1'b1;
      @(negedge core_clk);
      sample_valid = 1'b0;
      sample_data = ~d;
   endtask
   task wr32(input logic [31:0] v);
      for (int i = 3; i >= 0; i--)
         acs_cpu_model_i.wr(8'hE2 + 8'(i), v[8*i +: 8]);
   endtask
   task rd32(output logic [31:0] v);
      for (int i = 3; i >= 0; i--) begin
         acs_cpu_model_i.rd(8'hE2 + 8'(i), rv);
         v[8*i +: 8] = rv;
      end
   endtask
   task t_reset;
      for (int i = 0; i < 11; i++) begin
         acs_cpu_model_i.rd(8'hDC + 8'(i), rv);
         chk("rst", i == 0 ? 8'h30 : i == 2 ? 8'h1B : i == 3 ? 8'h06 : 8'h00, rv);
      end
      chk("dr", 11'h61B, decimation_ratio);
      chk("c0", 3'b110, {reference_enable, reference_level_select, input_buffer_enable});
   endtask
   task t_ctrl;
      logic [7:0] wd;
      for (int i = 0; i < 8; i++) begin
         wd = {1'b0, i[0], i[1:0], 1'b0, i[2:0]};
         acs_cpu_model_i.wr(8'hDC, {2'b00, i[0], i[1], i[0], i[2:0]});
         chk("gain", 8'h01 << i, gain_value);
         chk("c0", {i[0], i[1], i[0]},
            {reference_enable, reference_level_select, input_buffer_enable});
         acs_cpu_model_i.wr(8'hDE, {i[2:0], 5'h0A});
         acs_cpu_model_i.wr(8'hDF, {5'h1F, ~i[2:0]});
         chk("dr", {~i[2:0], i[2:0], 5'h0A}, decimation_ratio);
         acs_cpu_model_i.wr(8'hE6, 8'h00);
         acs_cpu_model_i.wr(8'hDD, wd);
         chk("mode", {i[0], i[1:0]}, {signedness_select, filter_settling_select});
         chk("cal", i > 5 ? 0 : i, trim_mode_select);
         acs_cpu_model_i.rd(8'hDD, rv);
         chk("c1rd", wd & 8'h70, rv);
         acs_cpu_model_i.wr(8'hE6, {i[0], 4'h0, i[2:1], 1'b0});
         chk("trim", {i[2:1] != 2'b00, i[0], 4'h0, i[2:1], 1'b0},
            {trim_active, trim_negative, trim_magnitude});
      end
   endtask
   task t_cpu;
      wr32(32'h12345678);
      rd32(acc);
      chk("add", 32'h12345678, acc);
      wr32(32'hFFFFFFFF);
      rd32(acc);
      chk("add2", 32'h12345677, acc);
      acs_cpu_model_i.wr(8'hE1, 8'h83);
      repeat (5) @(negedge core_clk);
      rd32(acc);
      chk("shift", 32'h01234567, acc);
      acs_cpu_model_i.wr(8'hE1, 8'h00);
      rd32(acc);
      chk("clear", 0, acc);
   endtask
   task t_sum(input logic [7:0] c1, cc, input logic [23:0] s0, s1, input logic [31:0] e);
      acs_cpu_model_i.wr(8'hDD, c1);
      acs_cpu_model_i.wr(8'hE1, 8'h00);
      acs_cpu_model_i.wr(8'hE1, cc);
      smp(s0);
      chk("early", 0, sum_irq);
      smp(s1);
      for (int i = 0; i < 20 && sum_irq !== 1'b1; i++)
         @(negedge core_clk);
      chk("irq", 1, sum_irq);
      rd32(acc);
      chk("sum", e, acc);
      chk("irqclr", 0, sum_irq);
   endtask
   task t_pwr;
      int n;
      for (int k = 0; k < 2; k++) begin
         clock_divider = (k == 0) ? 7'h03 : 7'h05;
         n = 0;
         while (converter_clk_en !== 1'b1 && n < 10) begin
            @(negedge core_clk);
            n++;
         end
         n = 0;
         do begin
            @(negedge core_clk);
            n++;
         end while (converter_clk_en !== 1'b1 && n < 10);
         chk("div", (k == 0) ? 4 : 6, n);
      end
      converter_powerdown = 1'b1;
      acs_cpu_model_i.wr(8'hE1, 8'h40);
      smp(24'h000001);
      smp(24'h000002);
      chk("pd", 0, {converter_power_on, reference_enable, sum_irq});
      converter_powerdown = 1'b0;
   endtask
   initial begin
      repeat (4) @(posedge core_clk);
      @(negedge core_clk);
      rstn = 1'b1;
      t_reset();
      t_ctrl();
      t_cpu();
      t_sum(8'h00, 8'h40, 24'hFFFFFE, 24'h000005, 32'h00000003);
      t_sum(8'h40, 8'h40, 24'hFFFFFE, 24'h000002, 32'h01000000);
      t_sum(8'h00, 8'hC0, 24'h000010, 24'h000010, 32'h00000010);
      t_pwr();
      final_report();
   end
endmodule // testbench
